/* rtl/lane_drive_pkg.sv */
// Constants for the per-lane drive and equalizer register bank
package lane_drive_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LANES = 3;
   localparam logic [7:0] LANE0_DRIVE_OFS = 8'h32;
   localparam logic [7:0] LANE1_DRIVE_OFS = 8'h33;
   localparam logic [7:0] LANE2_DRIVE_OFS = 8'h34;
   localparam logic [7:0] RSVD_A_OFS = 8'h35;
   localparam logic [7:0] RSVD_B_OFS = 8'h4D;
   localparam logic [7:0] EQ_L1L2_OFS = 8'h4E;
   localparam logic [7:0] EQ_CLKL0_OFS = 8'h4F;
   // Field positions
   localparam int SWING_HI = 7;
   localparam int SWING_LO = 5;
   localparam int EMPH_HI = 4;
   localparam int EMPH_LO = 3;
   localparam int EQ_HI_HI = 7;
   localparam int EQ_HI_LO = 4;
   localparam int EQ_LO_HI = 3;
   localparam int EQ_LO_LO = 0;
   // Mode control bit positions
   localparam int MODE_ALT_BIT = 5;
   localparam int MODE_INDIV_BIT = 6;
   localparam int MODE_SWAP_BIT = 7;
   // Reset values and fixed emphasis and read codes
   localparam logic [2:0] SWING_RST = 3'h0;
   localparam logic [1:0] EMPH_RST = 2'h0;
   localparam logic [3:0] EQ_RST = 4'h0;
   localparam logic EN_RST = 1'b1;
   localparam logic [1:0] EMPH_NONE = 2'h0;
   localparam logic [1:0] EMPH_RSVD = 2'h3;
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : lane_drive_pkg

/* rtl/lane_reg_word.sv */
// One byte-wide configuration register with write strobe and reset value
`timescale 1ns/1ps
module lane_reg_word #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock,
   input wire logic rstN,
   input wire logic wrEn,
   input wire logic [WIDTH-1:0] wrMask,
   input wire logic [WIDTH-1:0] wrData,
   output logic [WIDTH-1:0] value
);
   // Masked update keeps unwritable bits at their held value
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         value <= RESET_VALUE;
      end else if (wrEn) begin
         value <= (value & ~wrMask) | (wrData & wrMask);
      end
   end
endmodule : lane_reg_word

/* rtl/per_lane_drive_eq_regs.sv */
// Per-lane swing, pre-emphasis, equalizer and enable register bank
`timescale 1ns/1ps
module per_lane_drive_eq_regs
   import lane_drive_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   input wire logic [lane_drive_pkg::ADDR_W-1:0] regAddr,
   input wire logic [lane_drive_pkg::DATA_W-1:0] wrData,
   input wire logic [7:0] modeControl,
   input wire logic [2:0] globalSwing,
   input wire logic [1:0] globalEmphasis,
   input wire logic [3:0] laneEnableIn,
   input wire logic clockOnLaneTwo,
   output logic [lane_drive_pkg::DATA_W-1:0] rdData,
   output logic rdValid,
   output logic [8:0] laneSwing,
   output logic [5:0] laneEmphasis,
   output logic [15:0] laneEqualizer,
   output logic [3:0] laneActive
);
   import lane_drive_pkg::*;

   logic rstMeta;
   logic rstN;
   logic [7:0] driveReg [LANES];
   logic [7:0] eqL1L2;
   logic [7:0] eqClkL0;
   logic altMode;
   logic indivCtl;
   logic swapSet;
   logic [LANES-1:0] hitDrive;
   logic [7:0] next_rdData;
   logic [8:0] next_laneSwing;
   logic [5:0] next_laneEmphasis;
   logic [15:0] next_laneEqualizer;

   // Reset release through two flops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // Mode bits decoded from the mode control register
   assign altMode = modeControl[MODE_ALT_BIT];
   assign indivCtl = modeControl[MODE_INDIV_BIT];
   assign swapSet = modeControl[MODE_SWAP_BIT];

   // Drive registers per data lane; bits 2:0 never stored
   generate
      for (genvar g = 0; g < LANES; g++) begin : gDrive
         logic [7:0] mask;
         always_comb begin
            mask = 8'hF8;
            if (g == 2 && !altMode && swapSet) begin
               mask = 8'hE0; // Lane 2 emphasis write ignored
            end
         end
         // Write hit on this lane's drive register
         assign hitDrive[g] = wrStrobe &&
            regAddr == LANE0_DRIVE_OFS + 8'(g);
         lane_reg_word #(
            .WIDTH(8),
            .RESET_VALUE({SWING_RST, EMPH_RST, 3'h0})
         ) uDrive (
            .clock(clock),
            .rstN(rstN),
            .wrEn(hitDrive[g]),
            .wrMask(mask),
            .wrData(wrData),
            .value(driveReg[g])
         );
      end
   endgenerate

   // Lane 1 and lane 2 equalizer nibbles
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         eqL1L2 <= {EQ_RST, EQ_RST};
      end else if (wrStrobe && regAddr == EQ_L1L2_OFS) begin
         eqL1L2 <= wrData;
      end
   end

   // Clock lane and lane 0 equalizer nibbles
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         eqClkL0 <= {EQ_RST, EQ_RST};
      end else if (wrStrobe && regAddr == EQ_CLKL0_OFS) begin
         eqClkL0 <= wrData;
      end
   end

   // Readback; reserved and unmapped read zero
   always_comb begin
      next_rdData = READ_ZERO;
      if (regAddr == LANE0_DRIVE_OFS) begin
         next_rdData = driveReg[0];
      end else if (regAddr == LANE1_DRIVE_OFS) begin
         next_rdData = driveReg[1];
      end else if (regAddr == LANE2_DRIVE_OFS) begin
         next_rdData = driveReg[2];
      end else if (regAddr == EQ_L1L2_OFS) begin
         next_rdData = eqL1L2;
      end else if (regAddr == EQ_CLKL0_OFS) begin
         next_rdData = eqClkL0;
      end
   end

   // Read data held until the next read
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         rdData <= READ_ZERO;
      end else if (rdStrobe) begin
         rdData <= next_rdData;
      end
   end

   // Read answer strobe, one cycle after the request
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         rdValid <= 1'b0;
      end else begin
         rdValid <= rdStrobe;
      end
   end

   // Effective per-lane swing and emphasis, one lane per pass
   generate
      for (genvar g = 0; g < LANES; g++) begin : gSelect
         logic [2:0] swingSel;
         logic [1:0] emphSel;
         logic plainClock;

         // Only lane 2 can carry the clock in the default video mode
         assign plainClock = (g == 2) && !altMode && clockOnLaneTwo;

         // Swing follows the lane register only under individual control
         always_comb begin
            swingSel = globalSwing;
            if (altMode && indivCtl) begin
               swingSel = driveReg[g][SWING_HI:SWING_LO];
            end
         end

         // Emphasis likewise; reserved code and clock lane stay plain
         always_comb begin
            emphSel = globalEmphasis;
            if (altMode && indivCtl) begin
               emphSel = driveReg[g][EMPH_HI:EMPH_LO];
            end
            if (emphSel == EMPH_RSVD) begin
               emphSel = EMPH_NONE; // Reserved code
            end
            if (plainClock) begin
               emphSel = EMPH_NONE; // Clock lane kept plain
            end
         end

         // Lane slices of the next output words
         assign next_laneSwing[g*3 +: 3] = swingSel;
         assign next_laneEmphasis[g*2 +: 2] = emphSel;
      end
   endgenerate

   // Equalizer codes reach the lanes only under individual control
   always_comb begin
      next_laneEqualizer = {EQ_RST, EQ_RST, EQ_RST, EQ_RST};
      if (altMode && indivCtl) begin
         next_laneEqualizer = {eqClkL0[EQ_HI_HI:EQ_HI_LO],
                               eqL1L2[EQ_LO_HI:EQ_LO_LO],
                               eqL1L2[EQ_HI_HI:EQ_HI_LO],
                               eqClkL0[EQ_LO_HI:EQ_LO_LO]};
      end
   end

   // Registered swing and emphasis outputs
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         laneSwing <= {SWING_RST, SWING_RST, SWING_RST};
         laneEmphasis <= {EMPH_RST, EMPH_RST, EMPH_RST};
      end else begin
         laneSwing <= next_laneSwing;
         laneEmphasis <= next_laneEmphasis;
      end
   end

   // Registered equalizer output
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         laneEqualizer <= {EQ_RST, EQ_RST, EQ_RST, EQ_RST};
      end else begin
         laneEqualizer <= next_laneEqualizer;
      end
   end

   // Registered lane enables
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         laneActive <= {EN_RST, EN_RST, EN_RST, EN_RST};
      end else begin
         laneActive <= laneEnableIn; // Zero disables the lane
      end
   end
endmodule : per_lane_drive_eq_regs

/* test/lane_regs_monitor.sv */
// Checker of the lane register bank port behaviour
`timescale 1ns/1ps
module lane_regs_monitor (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic rdStrobe,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] modeControl,
   input wire logic [2:0] globalSwing,
   input wire logic [1:0] globalEmphasis,
   input wire logic [3:0] laneEnableIn,
   input wire logic clockOnLaneTwo,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic [8:0] laneSwing,
   input wire logic [5:0] laneEmphasis,
   input wire logic [15:0] laneEqualizer,
   input wire logic [3:0] laneActive
);
   logic [2:0] up;
   logic glob;
   // Skips the reset synchroniser delay
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) up <= 3'h0;
      else if (up != 3'h4) up <= up + 3'h1;
   end
   assign glob = !(modeControl[5] && modeControl[6]);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n || up != 3'h4);
   a_rsvd_zero: assert property (rdStrobe && regAddr == 8'h35 |=>
      rdValid && rdData == 8'h00) else $error("reserved read nonzero");
   a_drive_low: assert property (rdStrobe && regAddr == 8'h34 |=>
      rdData[2:0] == 3'h0) else $error("low drive bits nonzero");
   a_emph_legal: assert property (!(&laneEmphasis[1:0] ||
      &laneEmphasis[3:2] || &laneEmphasis[5:4])) else $error("emphasis 11");
   a_glob_swing: assert property ($past(glob) |->
      laneSwing == {3{$past(globalSwing)}}) else $error("swing not global");
   a_glob_emph: assert property (
      $past(glob && globalEmphasis != 2'h3) |->
      laneEmphasis[3:0] == {2{$past(globalEmphasis)}}) else $error("emph");
   a_clock_noemph: assert property (
      $past(!modeControl[5] && clockOnLaneTwo) |-> laneEmphasis[5:4] == 2'h0)
      else $error("clock lane emphasis");
   a_eq_global: assert property ($past(glob) |->
      laneEqualizer == 16'h0) else $error("equalizer applied");
   a_enable_copy: assert property (laneActive == $past(laneEnableIn))
      else $error("lane enable mismatch");
endmodule : lane_regs_monitor
bind per_lane_drive_eq_regs lane_regs_monitor i_lane_regs_monitor (.*);

/* test/lane_host_model.sv */
// Register bus host issuing single-byte writes and reads
`timescale 1ns/1ps
module lane_host_model (
   input wire logic clock,
   input wire logic rdValid,
   input wire logic [7:0] rdData,
   output logic wrStrobe,
   output logic rdStrobe,
   output logic [7:0] regAddr,
   output logic [7:0] wrData
);
   // Idle bus before the first request
   initial begin
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      regAddr = 8'h00;
      wrData = 8'h00;
   end
   // Write pulse; released lines show the inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wrStrobe <= 1'b1;
      regAddr <= a;
      wrData <= d;
      @(posedge clock);
      wrStrobe <= 1'b0;
      regAddr <= ~a;
      wrData <= ~d;
   endtask : wr
   // Read pulse; data taken with the valid pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clock);
      rdStrobe <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      rdStrobe <= 1'b0;
      regAddr <= ~a;
      @(negedge clock);
      v = rdValid;
      d = rdData;
   endtask : rd
endmodule : lane_host_model

/* test/per_lane_drive_eq_regs_tb.sv */
// Random and corner tests of the lane register bank
`timescale 1ns/1ps
module per_lane_drive_eq_regs_tb;
   logic clock = 1'b0, arst_n = 1'b0, clockOnLaneTwo = 1'b0, v, per;
   logic wrStrobe, rdStrobe, rdValid;
   logic [7:0] regAddr, wrData, rdData, rd, modeControl = 8'h00;
   logic [2:0] globalSwing = 3'h0;
   logic [1:0] globalEmphasis = 2'h0, em;
   logic [3:0] laneEnableIn = 4'h0, laneActive;
   logic [8:0] laneSwing, sw;
   logic [5:0] laneEmphasis, ep;
   logic [15:0] laneEqualizer, eq;
   logic [7:0] sh [8];
   logic [7:0] adr [8] = '{8'h32, 8'h33, 8'h34, 8'h40, 8'h35, 8'h4E,
      8'h4F, 8'h4D};
   int fails = 0, total_checks = 0, seed = 32'hdd1f;
   always #2.5 clock = ~clock;
   per_lane_drive_eq_regs i_per_lane_drive_eq_regs (.*);
   lane_host_model i_lane_host_model (.*);
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic test_done;
      if (fails == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // Rebuilds the lane outputs from the shadow copy and mode inputs
   task automatic lanes;
      per = modeControl[5] & modeControl[6];
      for (int l = 0; l < 3; l++) begin
         sw[l*3+:3] = per ? sh[l][7:5] : globalSwing;
         em = per ? sh[l][4:3] : globalEmphasis;
         if (em == 2'h3 || (l == 2 && !modeControl[5] && clockOnLaneTwo))
            em = 2'h0;
         ep[l*2+:2] = em;
      end
      eq = per ? {sh[6][7:4], sh[5][3:0], sh[5][7:4], sh[6][3:0]} : 16'h0;
      repeat (3) @(negedge clock);
      chk(16'(laneSwing), 16'(sw));
      chk(16'(laneEmphasis), 16'(ep));
      chk(laneEqualizer, eq);
      chk(16'(laneActive), 16'(laneEnableIn));
   endtask : lanes
   // Cuts a hang short
   initial begin
      #50000;
      fails++;
      test_done;
   end
   // Reset values, then random traffic over every mode combination
   initial begin
      logic [31:0] r;
      repeat (2) @(posedge clock);
      chk(16'(laneActive), 16'h000F);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         sh[i] = 8'h00;
         i_lane_host_model.rd(adr[i], rd, v);
         chk(16'({v, rd}), 16'h0100);
      end
      for (int k = 0; k < 40; k++) begin
         @(posedge clock);
         r = $random(seed);
         modeControl <= {k < 8 ? k[2:0] : r[7:5], r[4:0]};
         globalSwing <= r[10:8];
         globalEmphasis <= r[11] ? 2'h2 : {1'b0, r[12]};
         laneEnableIn <= r[16:13];
         clockOnLaneTwo <= r[17];
         for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            i_lane_host_model.wr(adr[i], r[7:0]);
            if (i == 5 || i == 6) sh[i] = r[7:0];
            else if (i < 3) sh[i][7:5] = r[7:5];
            if (i < 2 || (i == 2 && (modeControl[5] || !modeControl[7])))
               sh[i][4:3] = r[4:3];
         end
         for (int i = 0; i < 8; i++) begin
            i_lane_host_model.rd(adr[i], rd, v);
            chk(16'({v, rd}), 16'({1'b1, sh[i]}));
         end
         lanes;
      end
      test_done;
   end
endmodule : per_lane_drive_eq_regs_tb
